// ===== rtl/itmr_pkg.sv
package itmr_pkg;
	localparam int unsigned CNT_W      = 16;
	localparam int unsigned SCL_W      = 8;
	localparam logic [7:0]  OFF_COUNT  = 8'h00;
	localparam logic [7:0]  OFF_SCALE  = 8'h04;
	localparam logic [7:0]  OFF_PERIOD = 8'h08;
	localparam logic [7:0]  OFF_CTRL   = 8'h0C;
	localparam logic [7:0]  OFF_STATUS = 8'h10;
	localparam logic [7:0]  OFF_MASK   = 8'h14;
	localparam int unsigned CTRL_RUN   = 0;
	localparam int unsigned EV_ZERO    = 0;
	localparam logic [15:0] RST_COUNT  = 16'h0000;
	localparam logic [7:0]  RST_SCALE  = 8'h00;
	localparam logic [15:0] RST_PERIOD = 16'h0000;
endpackage : itmr_pkg

// ===== rtl/itmr_prescale.sv
module itmr_prescale #(
	parameter int unsigned W = 8
) (
	// Clocking
	input  wire logic         core_clk,
	input  wire logic         rst_n,
	input  wire logic         clk_en,
	// Control
	input  wire logic         run,
	input  wire logic [W-1:0] scale,
	// Tick out
	output logic              tick
);
	logic [W-1:0] left;

	// Expires after scale+1 cycles; restart counts from the live scale value
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			left <= '0;
		else if (clk_en)
		begin
			if (!run || left == '0)
				left <= scale;
			else
				left <= left - 1'b1;
		end
	end

	assign tick = clk_en && run && (left == '0);
endmodule : itmr_prescale

// ===== rtl/itmr_top.sv
// The placing of the registers and the APB slave port were decided locally.
module itmr_top (
	// Clocking
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        clk_en,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Interrupt
	output logic             irq
);
	logic [15:0] timer_count;
	logic [7:0]  timer_scale;
	logic [15:0] timer_period;
	logic        run;
	logic        status;
	logic        mask;
	logic        tick;
	logic        zero_ev;
	logic        wr;
	logic        hit;
	logic [31:0] next_rdata;

	assign wr = psel && penable && pwrite && clk_en;
	assign pready = 1'b1;

	always_comb
	begin
		hit = 1'b1;
		next_rdata = 32'h0000_0000;
		case (paddr)
			itmr_pkg::OFF_COUNT:  next_rdata = {16'h0000, timer_count};
			itmr_pkg::OFF_SCALE:  next_rdata = {24'h00_0000, timer_scale};
			itmr_pkg::OFF_PERIOD: next_rdata = {16'h0000, timer_period};
			itmr_pkg::OFF_CTRL:   next_rdata = {31'h0, run};
			itmr_pkg::OFF_STATUS: next_rdata = {31'h0, status};
			itmr_pkg::OFF_MASK:   next_rdata = {31'h0, mask};
			default:              hit = 1'b0;
		endcase
	end

	assign prdata = (psel && penable && !pwrite) ? next_rdata : 32'h0000_0000;
	assign pslverr = psel && penable && !hit;

	itmr_prescale #(
		.W (itmr_pkg::SCL_W)
	) u_pre (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.clk_en   (clk_en),
		.run      (run),
		.scale    (timer_scale),
		.tick     (tick)
	);

	// Zero reached on a decrement from one
	assign zero_ev = tick && (timer_count == 16'h0001);

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			timer_scale  <= itmr_pkg::RST_SCALE;
			timer_period <= itmr_pkg::RST_PERIOD;
			run          <= 1'b0;
			mask         <= 1'b0;
		end
		else if (wr && pstrb[0])
		begin
			case (paddr)
				itmr_pkg::OFF_SCALE:  timer_scale <= pwdata[7:0];
				itmr_pkg::OFF_PERIOD: timer_period <= pwdata[15:0];
				itmr_pkg::OFF_CTRL:   run <= pwdata[itmr_pkg::CTRL_RUN];
				itmr_pkg::OFF_MASK:   mask <= pwdata[itmr_pkg::EV_ZERO];
				default:              ;
			endcase
		end
	end

	// Timer tick wins over a software write in the same cycle
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			timer_count <= itmr_pkg::RST_COUNT;
		else if (clk_en)
		begin
			if (tick && timer_count <= 16'h0001)
				timer_count <= timer_period;
			else if (tick)
				timer_count <= timer_count - 16'h0001;
			else if (wr && paddr == itmr_pkg::OFF_COUNT)
				timer_count <= pwdata[15:0];
		end
	end

	// Sticky; set beats a write-one clear
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			status <= 1'b0;
		else if (clk_en)
		begin
			if (zero_ev)
				status <= 1'b1;
			else if (wr && paddr == itmr_pkg::OFF_STATUS
				&& pwdata[itmr_pkg::EV_ZERO])
				status <= 1'b0;
		end
	end

	assign irq = status && mask;

	// Named steps that the first five properties below are built from
	sequence s_zero_hit;
		clk_en && zero_ev;
	endsequence

	sequence s_status_clear;
		wr && paddr == itmr_pkg::OFF_STATUS
			&& pwdata[itmr_pkg::EV_ZERO] && !zero_ev;
	endsequence

	// A tick in the same cycle drops the write, so only quiet cycles count
	sequence s_count_write;
		wr && paddr == itmr_pkg::OFF_COUNT && !tick;
	endsequence

	sequence s_scale_write;
		wr && pstrb[0] && paddr == itmr_pkg::OFF_SCALE;
	endsequence

	sequence s_tick_at_zero;
		clk_en && tick && timer_count == 16'h0000;
	endsequence

	a_zero_sets_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
		s_zero_hit |=> status)
		else $error("zero event did not set status");

	a_status_clears: assert property (@(posedge core_clk)
		disable iff (!rst_n)
		s_status_clear |=> !status)
		else $error("status not cleared by write of one");

	a_count_loads: assert property (@(posedge core_clk)
		disable iff (!rst_n)
		s_count_write |=> timer_count == $past(pwdata[15:0]))
		else $error("count write did not land");

	a_scale_loads: assert property (@(posedge core_clk)
		disable iff (!rst_n)
		s_scale_write |=> timer_scale == $past(pwdata[7:0]))
		else $error("scale write did not land");

	a_zero_count_reloads: assert property (@(posedge core_clk)
		disable iff (!rst_n)
		s_tick_at_zero |=> timer_count == $past(timer_period))
		else $error("counter stuck at zero");

	a_count_frozen: assert property (@(posedge core_clk)
		disable iff (!rst_n)
		!clk_en |=> timer_count == $past(timer_count))
		else $error("counter moved while clock enable low");

	a_stopped_no_tick: assert property (@(posedge core_clk)
		disable iff (!rst_n)
		!run |-> !tick)
		else $error("tick while timer stopped");

	a_mask_blocks_irq: assert property (@(posedge core_clk)
		disable iff (!rst_n)
		!mask |-> !irq)
		else $error("irq raised while masked");

	a_reset_clean: assert property (@(posedge core_clk)
		!rst_n |=> timer_count == itmr_pkg::RST_COUNT && !status && !run)
		else $error("state not cleared by reset");

	a_zero_reloads: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && zero_ev |=> timer_count == $past(timer_period))
		else $error("counter not reloaded");
	a_tick_decrements: assert property (@(posedge core_clk)
		disable iff (!rst_n)
		clk_en && tick && timer_count > 16'h0001
		|=> timer_count == $past(timer_count) - 16'h0001)
		else $error("counter did not decrement");
	a_irq_follows: assert property (@(posedge core_clk) disable iff (!rst_n)
		irq == (status && mask))
		else $error("irq mismatch");
endmodule : itmr_top

// ===== testbench/tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        core_clk;
	logic        rst_n;
	logic        clk_en;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        irq;
	logic [31:0] q;
	logic        slv;
	int          err_count = 0;
	int          checked = 0;
	int          cyc = 0;
	int          t0;
	itmr_top uut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq));
	initial
	begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	always @(posedge core_clk) cyc <= cyc + 1;
	task summarize;
		if (err_count == 0 && checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : summarize
	task chk(input string nm, input logic [31:0] e, input logic [31:0] v);
		checked++;
		if (v !== e)
		begin
			$display("wrong value %s exp %h got %h", nm, e, v);
			err_count++;
		end
	endtask : chk
	// Holds the request until pready is seen at a rising edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin @(posedge core_clk); n++; end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin err_count++; summarize(); end
		q = prdata; slv = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask : apb
	// Polls at the falling edge so the level is settled
	task wirq;
		int n;
		n = 0;
		do begin @(negedge core_clk); n++; end while (irq !== 1'b1 && n < 200);
		if (irq !== 1'b1) begin err_count++; summarize(); end
	endtask : wirq
	initial
	begin
		rst_n = 1'b0; clk_en = 1'b1; psel = 1'b0; penable = 1'b0;
		pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		apb(0, itmr_pkg::OFF_SCALE, 32'h0); chk("scale", 32'h0, q);
		apb(0, itmr_pkg::OFF_PERIOD, 32'h0); chk("period", 32'h0, q);
		apb(1, itmr_pkg::OFF_SCALE, 32'h2);
		apb(0, itmr_pkg::OFF_SCALE, 32'h0); chk("scale", 32'h2, q);
		apb(1, itmr_pkg::OFF_PERIOD, 32'h5);
		apb(1, itmr_pkg::OFF_COUNT, 32'h3);
		apb(1, itmr_pkg::OFF_MASK, 32'h1);
		apb(1, itmr_pkg::OFF_CTRL, 32'h1);
		wirq();
		@(posedge core_clk);
		clk_en <= 1'b0;
		// Frozen right after reload, so count shows the period
		apb(0, itmr_pkg::OFF_COUNT, 32'h0); chk("count", 32'h5, q);
		apb(0, itmr_pkg::OFF_STATUS, 32'h0); chk("status", 32'h1, q);
		clk_en <= 1'b1;
		apb(1, itmr_pkg::OFF_STATUS, 32'h1);
		@(negedge core_clk); chk("irq", 32'h0, {31'h0, irq});
		wirq(); t0 = cyc;
		apb(1, itmr_pkg::OFF_STATUS, 32'h1);
		wirq(); chk("interval", 32'hF, 32'(cyc - t0));
		apb(1, itmr_pkg::OFF_MASK, 32'h0);
		repeat (20) @(negedge core_clk);
		chk("masked irq", 32'h0, {31'h0, irq});
		apb(0, itmr_pkg::OFF_STATUS, 32'h0); chk("status", 32'h1, q);
		apb(0, 8'h20, 32'h0); chk("unmapped", 32'h1, {31'h0, slv});
		chk("unmapped data", 32'h0, q);
		@(posedge core_clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		apb(0, itmr_pkg::OFF_STATUS, 32'h0); chk("status rst", 32'h0, q);
		chk("irq rst", 32'h0, {31'h0, irq});
		apb(0, itmr_pkg::OFF_COUNT, 32'h0); chk("count rst", 32'h0, q);
		summarize();
	end
endmodule : tb
